// [include/plb_defs.svh]
// Offsets, field positions, reset values and timing counts of the bridge
// register logic. Definitions only; included by the package and modules.
`ifndef PLB_DEFS_SVH
`define PLB_DEFS_SVH

// Configuration space byte addresses
`define PLB_CFG_CMD 8'h04
`define PLB_CFG_INTLINE 8'h3c
`define PLB_CFG_MISC 8'h40
`define PLB_CFG_IFC 8'h4c

// Field positions
`define PLB_CMD_BM_BIT 2
`define PLB_IFC_AUTORST_BIT 16
`define PLB_MISC_SWRST_BIT 31
`define PLB_MISC_CONN_BIT 10

// I/O space offset of the legacy adapter word
`define PLB_IO_LEGACY 4'he

// Reset values
`define PLB_MISC_DMA_RST 4'h0
`define PLB_MISC_SPTP_RST 2'h1
`define PLB_MISC_CONN_RST 1'b0
`define PLB_INTLINE_RST 8'h00
`define PLB_CMD_RST 16'h0000
`define PLB_IFC_AUTORST_RST 1'b0
`define PLB_MISC_RSVD_RD 32'h0000_4800

// Legacy word constant bits: presence 1, isa dma disable 1, byte-only 0
`define PLB_LEGACY_FIXED 16'h9000

// Timing
`define PLB_CLK_PERIOD_NS 100
`define PLB_SRST_MIN_NS 14000
`define PLB_SRST_CYCLES ((`PLB_SRST_MIN_NS+`PLB_CLK_PERIOD_NS-1)/`PLB_CLK_PERIOD_NS)
`define PLB_SWRST_HOLD 3'h3

`endif

// [include/plb_pkg.sv]
// Types shared by the bridge register logic.
// Assumes plb_defs.svh is on the include path.
package plb_pkg;
	`include "plb_defs.svh"

	// Direct-I/O arbitration against master DMA
	typedef enum logic [1:0] {
		PLB_DIO_IDLE = 2'b00,
		PLB_DIO_HALTED = 2'b01,
		PLB_DIO_RESTART = 2'b10
	} plb_dio_t;
endpackage : plb_pkg

// [logic/plb_pulse.sv]
// Stretches a one-cycle trigger into an active-low reset pulse.
// Assumes TRIG comes from logic on the same clock.
`timescale 1ns/1ns
module plb_pulse #(
	parameter int CYCLES = 140
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Trigger and pulse
	input wire logic TRIG,
	output logic PULSE_N
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt;

	// A new trigger restarts the full length, so pulses never shorten
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cnt <= '0;
		else if (TRIG)
			cnt <= W'(CYCLES);
		else if (cnt != '0)
			cnt <= cnt - W'(1);
	end

	assign PULSE_N = (cnt == '0);
endmodule : plb_pulse

// [logic/plb_regs.sv]
// Bridge register logic: command, interrupt line, misc control, interface
// control, legacy adapter word, direct-I/O retry and bus request.
// Assumes host accesses are decoded on CLK; bus pins arrive unsynchronised.
//
// Contract
// - Bus-master fall self-resets when autoreset bit zero
// - Autoreset bit one blocks that self reset
// - Self reset clears DMA, equals bit-31 reset
// - Other interface control bits are reserved
// - Read-only legacy word at I/O offset 0xE
// - Legacy bits 3:0 DMA code, 0xF pseudo
// - DMA code mirrors misc control bits 3:0
// - Legacy bits 7:4 mirror interrupt line
// - Bits 8,9 mirror misc topology and speed
// - Bit 10 mirrors connector, drives connector pin
// - Legacy bit 11 always reads zero
// - Legacy bit 12 always reads one
// - Legacy bits 13,14 read zero
// - Legacy bit 15 always reads one
// - Direct-I/O during DMA retried, DMA halted, restart
// - Request dropped on foreign stop, reasserted after; once granted, a stop does not drop it
`timescale 1ns/1ns
`include "plb_defs.svh"
module plb_regs
	import plb_pkg::*;
#(
	parameter int SRST_CYCLES = `PLB_SRST_CYCLES
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Configuration access
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [7:0] CFG_ADDR,
	input wire logic [31:0] CFG_WDATA,
	input wire logic [3:0] CFG_BE,
	output logic [31:0] CFG_RDATA,
	// Direct-I/O access
	input wire logic IO_REQ,
	input wire logic [3:0] IO_ADDR,
	input wire logic [15:0] SIF_RDATA,
	output logic IO_ACK,
	output logic IO_RETRY,
	output logic [15:0] IO_RDATA,
	output logic DIO_GO,
	// DMA engine
	input wire logic DMA_ACTIVE,
	input wire logic DMA_WANT_BUS,
	output logic DMA_HALT,
	output logic DMA_CLEAR,
	output plb_pkg::plb_dio_t DIO_STATE,
	// Bus pins
	input wire logic STOP_N,
	input wire logic GNT_N,
	output logic REQ_N,
	// LAN side
	output logic LAN_RST_N,
	output logic CONNECTOR_TYPE_PIN
);
	logic [15:0] cmd;
	logic [7:0] intline;
	logic [3:0] misc_dma;
	logic [1:0] misc_sptp;
	logic misc_conn;
	logic misc_swrst;
	logic [2:0] swrst_cnt;
	logic ifc_autorst_off;
	logic bm_prev;
	logic sw_prev;
	logic self_rst_trig;
	logic bm_fall;
	logic [1:0] stop_sync;
	logic [1:0] gnt_sync;
	logic granted;
	plb_dio_t direct_io_access;
	plb_dio_t next_dio;

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte-enable merge of a write onto a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : be_merge

	// Legacy adapter word, built from live register state
	function automatic logic [15:0] legacy_word(input logic [3:0] dma,
		input logic [7:0] il, input logic [1:0] sptp, input logic conn);
		logic [15:0] w;
		w = `PLB_LEGACY_FIXED;
		w[3:0] = dma;
		w[7:4] = il[3:0];
		w[9:8] = sptp;
		w[10] = conn;
		return w;                               // bits 14:13 zero
	endfunction : legacy_word

	////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic [31:0] cmd_m;
	logic [31:0] il_m;
	logic [31:0] misc_m;
	logic [31:0] ifc_m;
	assign cmd_m = be_merge({16'h0000, cmd}, CFG_WDATA, CFG_BE);
	assign il_m = be_merge({24'h000000, intline}, CFG_WDATA, CFG_BE);
	assign misc_m = be_merge(32'h0000_0000, CFG_WDATA, CFG_BE);
	assign ifc_m = be_merge({15'h0000, ifc_autorst_off, 16'h0000},
		CFG_WDATA, CFG_BE);

	// Command register; only host configuration writes change it
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cmd <= `PLB_CMD_RST;
		else if (CFG_WR && CFG_ADDR == `PLB_CFG_CMD)
			cmd <= cmd_m[15:0];
	end

	// Interrupt line register
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			intline <= `PLB_INTLINE_RST;
		else if (CFG_WR && CFG_ADDR == `PLB_CFG_INTLINE)
			intline <= il_m[7:0];
	end

	// Misc control fields that the legacy word echoes
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			misc_dma <= `PLB_MISC_DMA_RST;
			misc_sptp <= `PLB_MISC_SPTP_RST;
			misc_conn <= `PLB_MISC_CONN_RST;
		end
		else if (CFG_WR && CFG_ADDR == `PLB_CFG_MISC)
		begin
			if (CFG_BE[0])
				misc_dma <= CFG_WDATA[3:0];
			if (CFG_BE[1])
			begin
				misc_sptp <= CFG_WDATA[9:8];
				misc_conn <= CFG_WDATA[`PLB_MISC_CONN_BIT];
			end
		end
	end

	// Software reset bit: writes while it is set are ignored; it self-clears after four clocks
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			misc_swrst <= 1'b0;
			swrst_cnt <= 3'h0;
		end
		else if (CFG_WR && CFG_ADDR == `PLB_CFG_MISC && !misc_swrst &&
			misc_m[`PLB_MISC_SWRST_BIT])
		begin
			misc_swrst <= 1'b1;
			swrst_cnt <= 3'h0;
		end
		else if (misc_swrst)
		begin
			if (swrst_cnt == `PLB_SWRST_HOLD)
				misc_swrst <= 1'b0;
			swrst_cnt <= swrst_cnt + 3'h1;
		end
	end

	// Interface control: only the autoreset bit is stored
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ifc_autorst_off <= `PLB_IFC_AUTORST_RST;
		else if (CFG_WR && CFG_ADDR == `PLB_CFG_IFC)
			ifc_autorst_off <= ifc_m[`PLB_IFC_AUTORST_BIT];
	end

	// Read data; reserved interface bits happen to return zero
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			CFG_RDATA <= 32'h0000_0000;
		else if (CFG_RD)
			case (CFG_ADDR)
				`PLB_CFG_CMD: CFG_RDATA <= {16'h0000, cmd};
				`PLB_CFG_INTLINE: CFG_RDATA <= {24'h000000, intline};
				`PLB_CFG_MISC: CFG_RDATA <= `PLB_MISC_RSVD_RD |
					{misc_swrst, 20'h00000, misc_conn, misc_sptp,
					intline[3:0], misc_dma};
				`PLB_CFG_IFC: CFG_RDATA <= {15'h0000, ifc_autorst_off,
					16'h0000};
				default: CFG_RDATA <= 32'h0000_0000;
			endcase
	end

	////////////////////////////////////////////////////////////////////
	// Self reset

	// Previous-clock copies give single-cycle edge detects
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			bm_prev <= 1'b0;
			sw_prev <= 1'b0;
		end
		else
		begin
			bm_prev <= cmd[`PLB_CMD_BM_BIT];
			sw_prev <= misc_swrst;
		end
	end

	// Both sources feed one pulse generator, so the resets are identical
	assign bm_fall = bm_prev && !cmd[`PLB_CMD_BM_BIT];
	assign self_rst_trig = (bm_fall && !ifc_autorst_off) ||
		(misc_swrst && !sw_prev);

	plb_pulse #(
		.CYCLES(SRST_CYCLES)
	) u_srst (
		.CLK(CLK),
		.ARST_N(ARST_N),
		.TRIG(self_rst_trig),
		.PULSE_N(LAN_RST_N)
	);

	// Pending DMA is dropped for the whole self reset
	assign DMA_CLEAR = !LAN_RST_N;
	assign CONNECTOR_TYPE_PIN = misc_conn;

	////////////////////////////////////////////////////////////////////
	// Direct-I/O arbitration against master DMA

	// Back-to-back access during RESTART is retried instead of corrupted
	always_comb
	begin
		next_dio = direct_io_access;
		case (direct_io_access)
			PLB_DIO_IDLE:
				if (IO_REQ && DMA_ACTIVE)
					next_dio = PLB_DIO_HALTED;
			PLB_DIO_HALTED:
				if (IO_REQ)
					next_dio = PLB_DIO_RESTART;
			PLB_DIO_RESTART:
				if (IO_REQ && DMA_ACTIVE)
					next_dio = PLB_DIO_HALTED;
				else
					next_dio = PLB_DIO_IDLE;
			default:
				next_dio = PLB_DIO_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			direct_io_access <= PLB_DIO_IDLE;
		else if (!LAN_RST_N)
			direct_io_access <= PLB_DIO_IDLE;
		else
			direct_io_access <= next_dio;
	end

	// Answer one clock after the request
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			IO_ACK <= 1'b0;
			IO_RETRY <= 1'b0;
			DIO_GO <= 1'b0;
			IO_RDATA <= 16'h0000;
		end
		else
		begin
			IO_RETRY <= IO_REQ && DMA_ACTIVE && direct_io_access != PLB_DIO_HALTED;
			IO_ACK <= IO_REQ && !(DMA_ACTIVE && direct_io_access != PLB_DIO_HALTED);
			DIO_GO <= IO_REQ && !(DMA_ACTIVE && direct_io_access != PLB_DIO_HALTED) &&
				IO_ADDR != `PLB_IO_LEGACY;
			if (IO_REQ)
				IO_RDATA <= (IO_ADDR == `PLB_IO_LEGACY) ?
					legacy_word(misc_dma, intline, misc_sptp, misc_conn) :
					SIF_RDATA;
		end
	end

	assign DMA_HALT = (direct_io_access == PLB_DIO_HALTED);
	assign DIO_STATE = direct_io_access;

	////////////////////////////////////////////////////////////////////
	// Bus request

	// Pins are synchronised before any decision looks at them
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			stop_sync <= 2'b11;
			gnt_sync <= 2'b11;
		end
		else
		begin
			stop_sync <= {stop_sync[0], STOP_N};
			gnt_sync <= {gnt_sync[0], GNT_N};
		end
	end

	// Ownership holds once granted, so a later stop does not drop it
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			granted <= 1'b0;
		else if (!DMA_WANT_BUS || !LAN_RST_N)
			granted <= 1'b0;
		else if (!REQ_N && !gnt_sync[1])
			granted <= 1'b1;
	end

	// Foreign stop while waiting backs the request off until it clears
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			REQ_N <= 1'b1;
		else
			REQ_N <= !(DMA_WANT_BUS && LAN_RST_N && direct_io_access != PLB_DIO_HALTED &&
				(granted || stop_sync[1]));
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	// Every check runs on the one clock and drops out during reset
	default clocking chk_clk @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	sequence s_bm_fall_write;
		CFG_WR && CFG_ADDR == `PLB_CFG_CMD && CFG_BE[0] &&
		cmd[`PLB_CMD_BM_BIT] && !CFG_WDATA[`PLB_CMD_BM_BIT];
	endsequence

	chk_autoreset_fire: assert property (
		s_bm_fall_write ##0 !ifc_autorst_off |-> ##2 !LAN_RST_N)
		else $error("bus-master clear did not self reset");

	chk_autoreset_block: assert property (
		s_bm_fall_write ##0 ifc_autorst_off ##1 !misc_swrst && LAN_RST_N
		|-> ##1 LAN_RST_N)
		else $error("self reset despite autoreset disabled");

	// Four cycles is the shortest pulse length ever configured
	chk_swreset_same: assert property (
		$rose(misc_swrst) |-> ##1 !LAN_RST_N [*4])
		else $error("software reset pulse missing or short");

	chk_swbit_clear: assert property (
		$rose(misc_swrst) |-> misc_swrst [*4] ##1 !misc_swrst)
		else $error("software reset bit held wrong length");

	// REQ_N is a register, so it answers the self reset one clock late
	chk_dma_cleared: assert property (
		!LAN_RST_N |-> DMA_CLEAR ##1 REQ_N && direct_io_access == PLB_DIO_IDLE)
		else $error("DMA not cleared during self reset");

	chk_legacy_fixed: assert property (
		$past(IO_REQ) && $past(IO_ADDR) == `PLB_IO_LEGACY |->
		IO_RDATA[15:11] == 5'h12)
		else $error("legacy constant bits wrong");

	chk_legacy_mirror: assert property (
		$past(IO_REQ) && $past(IO_ADDR) == `PLB_IO_LEGACY |->
		IO_RDATA[10:0] == {$past(misc_conn), $past(misc_sptp),
		$past(intline[3:0]), $past(misc_dma)})
		else $error("legacy word does not mirror registers");

	chk_conn_pin: assert property (
		CFG_WR && CFG_ADDR == `PLB_CFG_MISC && CFG_BE[1] |->
		##1 CONNECTOR_TYPE_PIN == $past(CFG_WDATA[10]))
		else $error("connector pin does not follow bit 10");

	sequence s_dio_under_dma;
		IO_REQ && DMA_ACTIVE && direct_io_access == PLB_DIO_IDLE && LAN_RST_N;
	endsequence

	chk_dio_retry: assert property (
		s_dio_under_dma |-> ##1 IO_RETRY && !IO_ACK && DMA_HALT)
		else $error("direct-I/O under DMA not retried");

	chk_dio_repeat: assert property (
		DMA_HALT && IO_REQ && LAN_RST_N |-> ##1 IO_ACK && !DMA_HALT)
		else $error("repeated direct-I/O did not complete");

	chk_req_backoff: assert property (
		!granted && !stop_sync[1] |-> ##1 REQ_N)
		else $error("request held during foreign stop");

	chk_req_return: assert property (
		DMA_WANT_BUS [*2] ##0 stop_sync[1] && LAN_RST_N && !DMA_HALT
		|-> ##1 !REQ_N)
		else $error("request not reasserted after stop");
endmodule : plb_regs

// [test/plb_bus_agent.sv]
// Far-side bus agent model: another master's stop and the arbiter's grant.
// Assumes the bench raises stop_on and grant_on just after a clock edge.
`timescale 1ns/1ns
module plb_bus_agent (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bridge request and bench commands
	input wire logic req_n,
	input wire logic stop_on,
	input wire logic grant_on,
	// Bus pins toward the bridge
	output logic stop_n,
	output logic gnt_n
);
	////////////////////////////////////////////////////////////////////////
	// Pins change on the clock like a real agent; grant only while requested
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stop_n <= 1'b1;
			gnt_n <= 1'b1;
		end
		else
		begin
			stop_n <= ~stop_on;
			gnt_n <= ~(grant_on && !req_n); // Grant falls away with request
		end
	end
endmodule : plb_bus_agent

// [test/pci_legacy_config_and_autoreset_tb.sv]
// Self-checking bench for the bridge register logic.
// Assumes plb_pkg and plb_regs are compiled first; short self reset.
`timescale 1ns/1ns
module pci_legacy_config_and_autoreset_tb;
	import plb_pkg::*;
	localparam int SRST = 4; // Short pulse keeps the run brief
	logic clk = 0, arst_n = 0, cfg_wr = 0, cfg_rd = 0, io_req = 0;
	logic dma_active = 0, dma_want_bus = 0, stop_on = 0, grant_on = 0;
	logic [7:0] cfg_addr = 0;
	logic [31:0] cfg_wdata = 0, cfg_rdata, d;
	logic [3:0] cfg_be = 0, io_addr = 0, dma, il;
	logic [15:0] sif_rdata = 0, io_rdata, w;
	logic io_ack, io_retry, dio_go, dma_halt, dma_clear, req_n, lan_rst_n;
	logic conn_pin, stop_n, gnt_n, conn;
	logic [1:0] sptp;
	logic [2:0] ans;
	plb_dio_t dio_state;
	int err_count = 0, checks = 0, seed = 32'hd224, cyc = 0, len, clr, i;
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	// Design and far-side agent
	plb_regs #(.SRST_CYCLES(SRST)) i_plb_regs (.CLK(clk), .ARST_N(arst_n),
		.CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr),
		.CFG_WDATA(cfg_wdata), .CFG_BE(cfg_be), .CFG_RDATA(cfg_rdata),
		.IO_REQ(io_req), .IO_ADDR(io_addr), .SIF_RDATA(sif_rdata),
		.IO_ACK(io_ack), .IO_RETRY(io_retry), .IO_RDATA(io_rdata),
		.DIO_GO(dio_go), .DMA_ACTIVE(dma_active),
		.DMA_WANT_BUS(dma_want_bus), .DMA_HALT(dma_halt),
		.DMA_CLEAR(dma_clear), .DIO_STATE(dio_state), .STOP_N(stop_n),
		.GNT_N(gnt_n), .REQ_N(req_n), .LAN_RST_N(lan_rst_n),
		.CONNECTOR_TYPE_PIN(conn_pin));
	plb_bus_agent i_plb_bus_agent (.clk(clk), .arst_n(arst_n),
		.req_n(req_n), .stop_on(stop_on), .grant_on(grant_on),
		.stop_n(stop_n), .gnt_n(gnt_n));
	////////////////////////////////////////////////////////////////////////
	// Helpers; every drive lands one step after a rising edge
	task close_out;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task cfg_w(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
		cfg_wr = 1;
		cfg_addr = a;
		cfg_wdata = v;
		cfg_be = be;
		tick(1);
		cfg_wr = 0;
		tick(1); // Strobe stays low one edge between writes
	endtask : cfg_w
	task cfg_r(input logic [7:0] a, output logic [31:0] v);
		cfg_rd = 1;
		cfg_addr = a;
		tick(1);
		cfg_rd = 0;
		tick(1);
		v = cfg_rdata;
	endtask : cfg_r
	// Answer is {ack, retry, go}; an idle clock after it keeps accesses apart
	task io_r(input logic [3:0] a, output logic [2:0] r, output logic [15:0] v);
		int n;
		io_req = 1;
		io_addr = a;
		tick(1);
		io_req = 0;
		for (n = 0; n < 3 && io_ack !== 1'b1 && io_retry !== 1'b1; n++)
			tick(1);
		r = {io_ack, io_retry, dio_go};
		v = io_rdata;
		tick(1);
	endtask : io_r
	task srst_len(output int n, output int c);
		int k;
		n = 0;
		c = 0;
		for (k = 0; k < 6 && lan_rst_n !== 1'b0; k++)
			tick(1);
		while (lan_rst_n === 1'b0 && n < 200)
		begin
			if (dma_clear === 1'b1)
				c++;
			n++;
			tick(1);
		end
	endtask : srst_len
	task wait_req(input logic lvl, input string m);
		int n;
		for (n = 0; n < 8 && req_n !== lvl; n++)
			tick(1);
		chk(req_n, lvl, m);
	endtask : wait_req
	function logic [15:0] legacy(logic [3:0] dm, logic [3:0] it,
		logic [1:0] sp, logic cn);
		return {1'b1, 2'b00, 1'b1, 1'b0, cn, sp, it, dm};
	endfunction : legacy
	////////////////////////////////////////////////////////////////////////
	// Hang guard: a run this short never nears the ceiling
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_count++;
			$display("FAIL %0t timeout", $time);
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		tick(5);
		arst_n = 1;
		cfg_r(8'h40, d);
		chk(d, 32'h0000_4900, "misc reset");
		io_r(4'he, ans, w);
		chk({ans, w}, {3'b100, 16'h9100}, "legacy reset");
		// Pseudo-DMA code first, then random fields
		for (i = 0; i < 8; i++)
		begin
			dma = (i == 0) ? 4'hf : 4'($random(seed));
			il = 4'($random(seed));
			sptp = 2'($random(seed));
			conn = 1'($random(seed));
			cfg_w(8'h3c, {24'h0, 4'($random(seed)), il}, 4'h1);
			cfg_w(8'h40, {21'h0, conn, sptp, 4'h0, dma}, 4'h3);
			io_r(4'he, ans, w);
			chk(w, legacy(dma, il, sptp, conn), "legacy word");
			chk(32'(conn_pin), 32'(conn), "connector pin");
		end
		// Access during DMA is retried once, then served
		dma_active = 1;
		sif_rdata = 16'($random(seed));
		io_r(4'h2, ans, w);
		chk({dma_halt, ans}, 4'b1010, "retry");
		chk(32'(dio_state), 32'(PLB_DIO_HALTED), "halted state");
		io_r(4'h2, ans, w);
		chk({dma_halt, ans, w}, {4'b0101, sif_rdata}, "repeat");
		chk(32'(dio_state), 32'(PLB_DIO_IDLE), "idle state");
		dma_active = 0;
		// Request drops for a foreign stop while waiting, returns after it, and holds once granted
		dma_want_bus = 1;
		wait_req(1'b0, "request");
		stop_on = 1;
		wait_req(1'b1, "stop drop");
		stop_on = 0;
		wait_req(1'b0, "reassert");
		grant_on = 1;
		tick(6);
		stop_on = 1;
		tick(6);
		chk(req_n, 1'b0, "granted hold");
		stop_on = 0;
		grant_on = 0;
		dma_want_bus = 0;
		// Bus-master fall and misc bit 31 give the same pulse
		cfg_w(8'h04, 32'h4, 4'hf);
		cfg_w(8'h04, 32'h0, 4'hf);
		srst_len(len, clr);
		chk(len, SRST, "bm self reset");
		chk(clr, SRST, "bm clear span");
		cfg_w(8'h40, 32'h8000_0000, 4'h8);
		srst_len(len, clr);
		chk(len, SRST, "bit31 reset");
		chk(clr, SRST, "bit31 clear span");
		// Autoreset bit set blocks the fall trigger
		cfg_w(8'h4c, 32'h0001_0000, 4'h4);
		cfg_r(8'h4c, d);
		chk(d & 32'h0001_0000, 32'h0001_0000, "autoreset bit");
		cfg_w(8'h04, 32'h4, 4'hf);
		cfg_w(8'h04, 32'h0, 4'hf);
		srst_len(len, clr);
		chk(len, 0, "blocked reset");
		cfg_w(8'h4c, 32'h0, 4'h4);
		tick(2);
		close_out();
	end
endmodule : pci_legacy_config_and_autoreset_tb
